// ---- hdl/dcid_cfg.svh ----
`ifndef DCID_CFG_SVH
`define DCID_CFG_SVH

// register byte offsets
`define DCID_CTRL_OFS        8'h00
`define DCID_CFG_OFS         8'h04
`define DCID_ASSIGN_OFS      8'h08
`define DCID_STATUS_OFS      8'h0c
`define DCID_FCLASS_OFS      8'h10
`define DCID_TAB_BASE        8'h40

// control vector field positions
`define DCID_ON_OFF1_POS     0
`define DCID_FRESET_POS      1
`define DCID_TORQUE_POS      2
`define DCID_MSEL_POS        3
`define DCID_RAMP_POS        5
`define DCID_INTEG_POS       6
`define DCID_PSET_POS        7
`define DCID_FBYP_POS        10
`define DCID_FIX_POS         11
`define DCID_CTRL_W          15

// configuration field positions
`define DCID_CFG_BUS_POS     0
`define DCID_CFG_PON_POS     1
`define DCID_CFG_LP_POS      2
`define DCID_CFG_VAR_POS     4
`define DCID_CFG_PER_POS     16

// reset values
`define DCID_CTRL_RST        15'h0000
`define DCID_CFG_RST         32'h03e8_0005
`define DCID_ASSIGN_RST      15'h7fff
`define DCID_FCLASS_RST      8'h00

`define DCID_FAULT_W         8
`define DCID_SPD_W           16

`endif

// ---- hdl/dcid_pkg.sv ----
package dcid_pkg;

    typedef enum logic [2:0] {
        DRV_OPERATE = 3'b001,
        DRV_FAULT   = 3'b010,
        DRV_INHIBIT = 3'b100
    } dcid_drive_e;

    typedef logic [1:0] dcid_resp_t;

    localparam dcid_resp_t RESP_OKAY   = 2'b00;
    localparam dcid_resp_t RESP_SLVERR = 2'b10;

endpackage

// ---- hdl/dcid_decoder.sv ----
// Functional notes
// - fault memory cleared and faults acknowledged only on rising edge of fault reset
// - faults of the power-cycle class stay latched despite a fault reset edge
// - fault state holds until all causes go and the fault memory is cleared; fieldbus mode then enters power-on inhibit
// - power-on inhibit config lets acknowledge pass with on/off1 high; drive stays inhibited in fieldbus mode only
// - torque mode input 1 gives open-loop torque control, 0 closed-loop speed
// - two motor select bits, first is low bit, values 0..3 pick sets 1..4
// - motor selected outputs follow the active motor data set for contactor switching
// - ramp bypass 1 disables the ramp generator as zero ramp times, 0 enables it
// - integrator inhibit 1 clears and holds the speed integral term, 0 normal
// - three parameter set bits, first is low bit, select parameter sets 0..7
// - selection bits with no input assigned read as 0 in terminal mode
// - four fixed speed bits; 0 cancels, 1..15 apply stored fixed setpoint
// - with fixed setpoint cancelled the analog setpoint is used
// - first setpoint filter switched in or out by the bypass input level
// - filter bypass 1 disables the low-pass filter, 0 enables it
// - filter bypass honoured only when the filter is configured as low-pass
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`include "dcid_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dcid_decoder
    import dcid_pkg::*;
(
    // clock and reset
    input  wire logic                     CORE_CLK,
    input  wire logic                     RST,
    // axi4-lite write address
    input  wire logic [7:0]               S_AXI_AWADDR,
    input  wire logic                     S_AXI_AWVALID,
    output var  logic                     S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0]              S_AXI_WDATA,
    input  wire logic [3:0]               S_AXI_WSTRB,
    input  wire logic                     S_AXI_WVALID,
    output var  logic                     S_AXI_WREADY,
    // axi4-lite write response
    output var  logic [1:0]               S_AXI_BRESP,
    output var  logic                     S_AXI_BVALID,
    input  wire logic                     S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [7:0]               S_AXI_ARADDR,
    input  wire logic                     S_AXI_ARVALID,
    output var  logic                     S_AXI_ARREADY,
    output var  logic [31:0]              S_AXI_RDATA,
    output var  logic [1:0]               S_AXI_RRESP,
    output var  logic                     S_AXI_RVALID,
    input  wire logic                     S_AXI_RREADY,
    // input terminals and drive-side inputs
    input  wire logic [`DCID_CTRL_W-1:0]  TERM_IN,
    input  wire logic [`DCID_FAULT_W-1:0] FAULT_CAUSE,
    input  wire logic [`DCID_SPD_W-1:0]   ANALOG_SETPOINT,
    // decoded drive actions
    output var  logic [3:0]               MOTOR_SEL,
    output var  logic                     TORQUE_MODE,
    output var  logic                     RAMP_BYPASS,
    output var  logic                     INTEG_INHIBIT,
    output var  logic [2:0]               PARAM_SET,
    output var  logic                     FILTER_BYPASS,
    output var  logic                     FIXED_ACTIVE,
    output var  logic [`DCID_SPD_W-1:0]   SPEED_SETPOINT,
    // fault handling
    output var  logic                     FAULT_ACK,
    output var  logic                     FAULT_ACTIVE,
    output var  logic                     POWER_ON_INHIBIT
);

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
        end
        return r;
    endfunction

    // binary selection field of a sampled control vector
    function automatic logic [3:0] field(input logic [`DCID_CTRL_W-1:0] v,
                                         input int pos,
                                         input int width);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < width; i++) begin
            r[i] = v[pos + i];
        end
        return r;
    endfunction

    // registers
    logic [`DCID_CTRL_W-1:0]   ctrl_reg;
    logic [31:0]               cfg_reg;
    logic [`DCID_CTRL_W-1:0]   assign_reg;
    logic [`DCID_FAULT_W-1:0]  fclass_reg;
    logic [`DCID_SPD_W-1:0]    fix_tab [1:15];

    // bus slave state
    logic                      aw_have_reg;
    logic [7:0]                aw_addr_reg;
    logic                      w_have_reg;
    logic [31:0]               w_data_reg;
    logic [3:0]                w_strb_reg;

    // terminal synchroniser
    logic [`DCID_CTRL_W-1:0]   term_s1_reg;
    logic [`DCID_CTRL_W-1:0]   term_s2_reg;
    logic [`DCID_CTRL_W-1:0]   term_s3_reg;
    logic [`DCID_CTRL_W-1:0]   term_reg;

    // interpolation clock and samples
    logic [15:0]               tick_cnt_reg;
    logic                      tick_reg;
    logic [`DCID_CTRL_W-1:0]   smp_reg;
    logic                      freset_prev_reg;
    logic [`DCID_FAULT_W-1:0]  fault_reg;
    dcid_drive_e               drv_reg;
    dcid_drive_e               drv_next;

    // ---------------- bus decode ----------------
    wire        bus_mode     = cfg_reg[`DCID_CFG_BUS_POS];
    wire        pon_cfg      = cfg_reg[`DCID_CFG_PON_POS];
    wire        lowpass_cfg  = cfg_reg[`DCID_CFG_LP_POS];
    wire [15:0] period       = cfg_reg[`DCID_CFG_PER_POS +: 16];

    wire        wr_go        = aw_have_reg && w_have_reg && !S_AXI_BVALID;
    wire        wr_ctrl      = wr_go && aw_addr_reg == `DCID_CTRL_OFS;
    wire        wr_cfg       = wr_go && aw_addr_reg == `DCID_CFG_OFS;
    wire        wr_assign    = wr_go && aw_addr_reg == `DCID_ASSIGN_OFS;
    wire        wr_fclass    = wr_go && aw_addr_reg == `DCID_FCLASS_OFS;
    wire [3:0]  wr_tidx      = aw_addr_reg[5:2];
    wire        wr_tab_hit   = aw_addr_reg[7:6] == 2'b01 && wr_tidx != 4'h0 && aw_addr_reg[1:0] == 2'b00;
    wire        wr_tab       = wr_go && wr_tab_hit;
    wire        wr_hit       = wr_ctrl || wr_cfg || wr_assign || wr_fclass || wr_tab
                               || (wr_go && aw_addr_reg == `DCID_STATUS_OFS);
    wire [31:0] wr_cfg_val   = wmerge(cfg_reg, w_data_reg, w_strb_reg);
    wire [31:0] wr_ctrl_val  = wmerge({17'h0, ctrl_reg}, w_data_reg, w_strb_reg);
    wire [31:0] wr_asg_val   = wmerge({17'h0, assign_reg}, w_data_reg, w_strb_reg);
    wire [31:0] wr_fcl_val   = wmerge({24'h0, fclass_reg}, w_data_reg, w_strb_reg);
    wire [31:0] wr_tab_val   = wmerge({16'h0, fix_tab[wr_tidx == 4'h0 ? 4'h1 : wr_tidx]}, w_data_reg, w_strb_reg);

    wire        rd_take      = S_AXI_ARVALID && S_AXI_ARREADY;
    wire [3:0]  rd_tidx      = S_AXI_ARADDR[5:2];
    wire        rd_tab       = S_AXI_ARADDR[7:6] == 2'b01 && rd_tidx != 4'h0 && S_AXI_ARADDR[1:0] == 2'b00;
    wire [31:0] status_word  = {8'h0, fault_reg, 5'h0, PARAM_SET, MOTOR_SEL,
                                1'b0, FIXED_ACTIVE, POWER_ON_INHIBIT, FAULT_ACTIVE};
    logic [31:0] rd_data;
    logic        rd_hit;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0;
        if (rd_tab) begin
            rd_data = {16'h0, fix_tab[rd_tidx]};
        end else begin
            unique case (S_AXI_ARADDR)
                `DCID_CTRL_OFS:   rd_data = {17'h0, ctrl_reg};
                `DCID_CFG_OFS:    rd_data = cfg_reg;
                `DCID_ASSIGN_OFS: rd_data = {17'h0, assign_reg};
                `DCID_STATUS_OFS: rd_data = status_word;
                `DCID_FCLASS_OFS: rd_data = {24'h0, fclass_reg};
                default:          rd_hit  = 1'b0;
            endcase
        end
    end

    // ---------------- bus slave ----------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            aw_have_reg   <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_have_reg    <= 1'b0;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            // ready is dropped once an item is held so each channel stalls alone
            S_AXI_AWREADY <= !aw_have_reg && !(S_AXI_AWVALID && S_AXI_AWREADY) && !wr_go;
            S_AXI_WREADY  <= !w_have_reg && !(S_AXI_WVALID && S_AXI_WREADY) && !wr_go;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !rd_take;
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_data;
                S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ---------------- software registers ----------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_reg   <= `DCID_CTRL_RST;
            cfg_reg    <= `DCID_CFG_RST;
            assign_reg <= `DCID_ASSIGN_RST;
            fclass_reg <= `DCID_FCLASS_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wr_ctrl_val[`DCID_CTRL_W-1:0];
            end
            if (wr_cfg) begin
                cfg_reg <= wr_cfg_val;
            end
            if (wr_assign) begin
                assign_reg <= wr_asg_val[`DCID_CTRL_W-1:0];
            end
            if (wr_fclass) begin
                fclass_reg <= wr_fcl_val[`DCID_FAULT_W-1:0];
            end
        end
    end

    // setpoint table holds data only, so it needs no reset
    always_ff @(posedge CORE_CLK) begin
        if (wr_tab) begin
            fix_tab[wr_tidx] <= wr_tab_val[`DCID_SPD_W-1:0];
        end
    end

    // ---------------- terminals ----------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            term_s1_reg <= '0;
            term_s2_reg <= '0;
            term_s3_reg <= '0;
            term_reg    <= '0;
        end else begin
            term_s1_reg <= TERM_IN;
            term_s2_reg <= term_s1_reg;
            term_s3_reg <= term_s2_reg;
            // a bit follows only when the second and third stage agree
            term_reg <= (term_s2_reg & term_s3_reg) | (term_reg & (term_s2_reg | term_s3_reg));
        end
    end

    // unassigned terminal bits read as 0; fieldbus mode takes the control word
    wire [`DCID_CTRL_W-1:0] ctrl_src = bus_mode ? ctrl_reg : (term_reg & assign_reg);

    // ---------------- interpolation clock ----------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            tick_cnt_reg <= 16'h0;
            tick_reg     <= 1'b0;
        end else begin
            tick_cnt_reg <= (tick_cnt_reg != 16'h0) ? tick_cnt_reg - 16'h1 : (period == 16'h0) ? 16'h0 : period - 16'h1;
            tick_reg     <= tick_cnt_reg == 16'h0;
        end
    end

    // ---------------- sampled decode ----------------
    wire [3:0]  s_msel    = field(smp_reg, `DCID_MSEL_POS, 2);
    wire [3:0]  s_pset    = field(smp_reg, `DCID_PSET_POS, 3);
    wire [3:0]  s_fix     = field(smp_reg, `DCID_FIX_POS, 4);
    wire        s_freset  = smp_reg[`DCID_FRESET_POS];
    wire        s_onoff1  = smp_reg[`DCID_ON_OFF1_POS];
    // steady levels of fault reset do nothing, only the 0 to 1 step
    wire        reset_edge = tick_reg && s_freset && !freset_prev_reg;
    wire        ack_ok    = reset_edge && (!s_onoff1 || pon_cfg);
    wire [`DCID_FAULT_W-1:0] clr_mask = ack_ok ? ~fclass_reg : '0;
    // a fault cause still present re-sets its bit, so the set wins over the clear
    wire [`DCID_FAULT_W-1:0] fault_next = (fault_reg & ~clr_mask) | FAULT_CAUSE;

    always_comb begin
        drv_next = drv_reg;
        unique case (drv_reg)
            DRV_OPERATE: begin
                if (fault_next != '0) begin
                    drv_next = DRV_FAULT;
                end
            end
            DRV_FAULT: begin
                if (fault_next == '0) begin
                    drv_next = bus_mode ? DRV_INHIBIT : DRV_OPERATE;
                end
            end
            DRV_INHIBIT: begin
                if (fault_next != '0) begin
                    drv_next = DRV_FAULT;
                end else if (tick_reg && !s_onoff1) begin
                    drv_next = DRV_OPERATE;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            smp_reg         <= '0;
            freset_prev_reg <= 1'b0;
            fault_reg       <= '0;
            drv_reg         <= DRV_OPERATE;
            FAULT_ACK       <= 1'b0;
            FAULT_ACTIVE    <= 1'b0;
            POWER_ON_INHIBIT <= 1'b0;
        end else begin
            // one sample per interpolation cycle makes multi-bit changes simultaneous
            if (tick_reg) begin
                smp_reg         <= ctrl_src;
                freset_prev_reg <= s_freset;
            end
            fault_reg        <= fault_next;
            drv_reg          <= drv_next;
            FAULT_ACK        <= ack_ok;
            FAULT_ACTIVE     <= drv_next == DRV_FAULT;
            POWER_ON_INHIBIT <= drv_next == DRV_INHIBIT;
        end
    end

    // ---------------- decoded actions ----------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            MOTOR_SEL      <= 4'h1;
            TORQUE_MODE    <= 1'b0;
            RAMP_BYPASS    <= 1'b0;
            INTEG_INHIBIT  <= 1'b0;
            PARAM_SET      <= 3'h0;
            FILTER_BYPASS  <= 1'b0;
            FIXED_ACTIVE   <= 1'b0;
            SPEED_SETPOINT <= '0;
        end else begin
            MOTOR_SEL     <= 4'h1 << s_msel[1:0];
            TORQUE_MODE   <= smp_reg[`DCID_TORQUE_POS];
            RAMP_BYPASS   <= smp_reg[`DCID_RAMP_POS];
            INTEG_INHIBIT <= smp_reg[`DCID_INTEG_POS];
            PARAM_SET     <= s_pset[2:0];
            // bypass has no meaning unless the filter is a low-pass type
            FILTER_BYPASS <= smp_reg[`DCID_FBYP_POS] && lowpass_cfg;
            FIXED_ACTIVE  <= s_fix != 4'h0;
            SPEED_SETPOINT <= (s_fix != 4'h0) ? fix_tab[s_fix] : ANALOG_SETPOINT;
        end
    end

endmodule // dcid_decoder

`default_nettype wire

// ---- bench/dcid_decoder_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module dcid_decoder_chk (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // register bus handshakes
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // drive side
    input wire logic [7:0]  FAULT_CAUSE,
    input wire logic [3:0]  MOTOR_SEL,
    input wire logic        FAULT_ACK,
    input wire logic        FAULT_ACTIVE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_bresp_clear: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response not withdrawn after handshake");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data changed before handshake");
    a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read accepted while data pending");
    a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    a_write_latency: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
                                      |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    a_ack_pulse: assert property (FAULT_ACK |=> !FAULT_ACK)
        else $error("fault acknowledge longer than one cycle");
    a_motor_onehot: assert property ($onehot(MOTOR_SEL))
        else $error("motor select not one-hot");
    a_fault_hold: assert property (|FAULT_CAUSE |=> FAULT_ACTIVE)
        else $error("fault state left with a cause present");
endmodule // dcid_decoder_chk

bind dcid_decoder dcid_decoder_chk chk_i (
    .CORE_CLK(CORE_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .FAULT_CAUSE(FAULT_CAUSE), .MOTOR_SEL(MOTOR_SEL),
    .FAULT_ACK(FAULT_ACK), .FAULT_ACTIVE(FAULT_ACTIVE)
);

`default_nettype wire

// ---- bench/dcid_plc_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module dcid_plc_model (
    // clock
    input  wire logic        clk,
    // requested control word and terminal drive
    input  wire logic [14:0] req_vec,
    output var  logic [14:0] term_out = 15'h0000
);
    // every bit moves on the same edge, so a multi-bit selection never shows a mixed value
    always @(posedge clk) begin
        term_out[14:1] <= req_vec[14:1];
        term_out[0]    <= req_vec[0] & ~req_vec[1];
    end
endmodule // dcid_plc_model

`default_nettype wire

// ---- bench/tb_drive_control_input_decoder.sv ----
`include "dcid_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_drive_control_input_decoder;
    import dcid_pkg::*;
    logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, fault_cause = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, torque, ramp, integ, fbyp, fixed, ack, factive, inhibit;
    logic [14:0] term_req = 0, term_in, v;
    logic [15:0] analog = 0, speed;
    logic [3:0]  motor;
    logic [2:0]  pset;
    int          seed = 32'h1326, n_errors = 0, check_count = 0, acks = 0, a0, k;

    dcid_decoder uut (
        .CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TERM_IN(term_in), .FAULT_CAUSE(fault_cause),
        .ANALOG_SETPOINT(analog), .MOTOR_SEL(motor), .TORQUE_MODE(torque), .RAMP_BYPASS(ramp),
        .INTEG_INHIBIT(integ), .PARAM_SET(pset), .FILTER_BYPASS(fbyp), .FIXED_ACTIVE(fixed),
        .SPEED_SETPOINT(speed), .FAULT_ACK(ack), .FAULT_ACTIVE(factive), .POWER_ON_INHIBIT(inhibit)
    );
    dcid_plc_model plc (.clk(clk), .req_vec(term_req), .term_out(term_in));

    always #2 clk = ~clk;
    always @(posedge clk) if (ack === 1'b1) acks <= acks + 1;

    function automatic logic [15:0] tab(input logic [3:0] n);
        return {n, 12'h0a5};
    endfunction
    function automatic logic [15:0] exp_spd(input logic [14:0] c, input logic [15:0] a);
        return (c[14:11] == 4'h0) ? a : tab(c[14:11]);
    endfunction

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic hang(input string m);
        chk(1'b0, m);
        report_and_stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] res);
        int i;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= x;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                res = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (i == 200) hang("write timeout");
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] res);
        int i;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                x = rdata;
                res = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (i == 200) hang("read timeout");
    endtask
    // control word lands at the next interpolation tick, period 4 here
    task automatic ctl(input logic [14:0] c);
        wr(`DCID_CTRL_OFS, {17'h0, c}, r);
        repeat (10) @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk(motor === 4'h1, "motor set after reset");
        rd(`DCID_CFG_OFS, d, r);
        chk(d === `DCID_CFG_RST && r === RESP_OKAY, "cfg reset value");
        rd(`DCID_ASSIGN_OFS, d, r);
        chk(d === {17'h0, `DCID_ASSIGN_RST}, "assign reset value");
        rd(8'h20, d, r);
        chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
        wr(8'h20, 32'h1, r);
        chk(r === RESP_SLVERR, "unmapped write");
        $display("register test done");
        for (k = 1; k < 16; k++) wr(8'(`DCID_TAB_BASE + 4 * k), {16'h0, tab(4'(k))}, r);
        wr(`DCID_CFG_OFS, 32'h0004_0005, r);
        // the period counter was loaded from the reset period; the new period applies after it runs out
        repeat (1000) @(posedge clk);
        for (k = 0; k < 40; k++) begin
            v = (k == 0) ? 15'h0000 : (k == 1) ? 15'h7ffd : 15'($random(seed));
            v[1] = 1'b0;
            analog <= 16'($random(seed));
            ctl(v);
            chk(torque === v[2], "torque mode");
            chk(motor === (4'h1 << v[4:3]), "motor set");
            chk(ramp === v[5] && integ === v[6], "ramp or integrator");
            chk(pset === v[9:7], "parameter set");
            chk(fbyp === v[10], "filter bypass");
            chk(fixed === (v[14:11] != 0) && speed === exp_spd(v, analog), "speed setpoint");
        end
        wr(`DCID_CFG_OFS, 32'h0004_0001, r);
        ctl(15'h0400);
        chk(fbyp === 1'b0, "bypass without lowpass");
        $display("decode test done");
        wr(`DCID_CFG_OFS, 32'h0004_0004, r);
        wr(`DCID_ASSIGN_OFS, 32'h0000_7eff, r);
        term_req <= 15'h7ffc;
        repeat (24) @(posedge clk);
        chk(pset === 3'h5 && motor === 4'h8 && torque === 1'b1, "terminal decode");
        term_req <= 15'h0000;
        wr(`DCID_CFG_OFS, 32'h0004_0005, r);
        ctl(15'h0000);
        $display("terminal test done");
        fault_cause <= 8'h01;
        repeat (2) @(posedge clk);
        chk(factive === 1'b1, "fault entered");
        fault_cause <= 8'h00;
        repeat (10) @(posedge clk);
        chk(factive === 1'b1, "fault kept at steady low");
        a0 = acks;
        ctl(15'h0002);
        chk(acks === a0 + 1 && factive === 1'b0, "fault acknowledged on edge");
        fault_cause <= 8'h01;
        @(posedge clk);
        fault_cause <= 8'h00;
        repeat (10) @(posedge clk);
        chk(acks === a0 + 1 && factive === 1'b1, "steady high ignored");
        ctl(15'h0001);
        ctl(15'h0003);
        chk(acks === a0 + 1 && factive === 1'b1, "ack refused with on command");
        wr(`DCID_CFG_OFS, 32'h0004_0007, r);
        ctl(15'h0001);
        ctl(15'h0003);
        chk(acks === a0 + 2 && factive === 1'b0 && inhibit === 1'b1, "ack with inhibit config");
        wr(`DCID_FCLASS_OFS, 32'h0000_0002, r);
        fault_cause <= 8'h02;
        @(posedge clk);
        fault_cause <= 8'h00;
        ctl(15'h0000);
        ctl(15'h0002);
        chk(factive === 1'b1, "power-cycle fault kept");
        rd(`DCID_STATUS_OFS, d, r);
        chk(d === 32'h0002_0011 && acks === a0 + 3, "latched power-cycle fault in status");
        $display("fault test done");
        report_and_stop();
    end
endmodule // tb_drive_control_input_decoder

`default_nettype wire
